// >>> hw/gpio_pin_config_data.sv
// eight-pin general-purpose port with timer event routing, wishbone registers
`timescale 1ns/1ps
module gpio_pin_config_data
  import gpio_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // wishbone slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [gpio_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  // timer compare events
  input  wire logic                    evt_a_i,
  input  wire logic                    evt_b_i,
  output logic [gpio_pkg::NUM_PINS-1:0] timer_clear_o,
  // pins
  input  wire logic [gpio_pkg::NUM_PINS-1:0] pin_i,
  output logic      [gpio_pkg::NUM_PINS-1:0] pin_o,
  output logic      [gpio_pkg::NUM_PINS-1:0] pin_oe_o,
  // interrupt
  output logic                         irq_o
);
  import gpio_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  pin_cfg_s   cfg;
  logic [7:0] dir;
  logic [7:0] data;
  logic [7:0] int_sts;
  logic [7:0] int_en;
  pin_drive_s drive;
  pin_drive_s next_drive;
  logic [7:0] level;
  logic [7:0] active;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire req       = cyc_i && stb_i && !ack_o;
  wire wr        = req && we_i;
  wire hit_cfg   = (adr_i == CFG_OFFSET);
  wire hit_dd    = (adr_i == DATA_DIR_OFFSET);
  wire hit_sts   = (adr_i == INT_STS_OFFSET);
  wire hit_clr   = (adr_i == INT_CLR_OFFSET);
  wire hit_en    = (adr_i == INT_EN_OFFSET);
  wire [7:0] is_out   = dir | cfg.evt_oe;
  wire [7:0] rd_data  = (is_out & data) | (~is_out & level);
  wire [7:0] clr_mask = (wr && hit_clr && sel_i[0]) ? dat_i[7:0] : 8'h00;
  wire [31:0] rd_mux  = hit_cfg ? {cfg.ch_sel, cfg.polarity, cfg.evt_oe, cfg.buf_pp} :
                        hit_dd  ? {8'h00, dir, 8'h00, rd_data} :
                        hit_sts ? {24'h0, int_sts} :
                        hit_en  ? {24'h0, int_en} : 32'h0;

  // ------------------------------------------------------------
  // register writes and bus answer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg   <= '0;
      dir   <= RESET_BYTE;
      data  <= RESET_BYTE;
      int_en <= RESET_BYTE;
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else if (ce_i) begin
      ack_o <= req;
      dat_o <= req && !we_i ? rd_mux : 32'h0;
      if (wr && hit_cfg) begin
        if (sel_i[3]) cfg.ch_sel   <= dat_i[31:24];
        if (sel_i[2]) cfg.polarity <= dat_i[23:16];
        if (sel_i[1]) cfg.evt_oe   <= dat_i[15:8];
        if (sel_i[0]) cfg.buf_pp   <= dat_i[7:0];
      end
      if (wr && hit_dd) begin
        if (sel_i[2]) dir  <= dat_i[23:16];
        if (sel_i[0]) data <= dat_i[7:0];
      end
      if (wr && hit_en && sel_i[0]) int_en <= dat_i[7:0];
    end
  end

  // ------------------------------------------------------------
  // per-pin input and output
  // ------------------------------------------------------------
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    pin_level_filter #(.MIN_CYC(MIN_PULSE_CYC)) u_filt (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .pin_i      (pin_i[p]),
      .polarity_i (cfg.polarity[p]),
      .level_o    (level[p]),
      .active_o   (active[p])
    );
    pin_driver u_drv (
      .data_i     (data[p]),
      .dir_i      (dir[p]),
      .evt_oe_i   (cfg.evt_oe[p]),
      .buf_pp_i   (cfg.buf_pp[p]),
      .polarity_i (cfg.polarity[p]),
      .evt_a_i    (evt_a_i),
      .evt_b_i    (evt_b_i),
      .ch_sel_i   (cfg.ch_sel[p]),
      .out_o      (next_drive.out[p]),
      .oe_o       (next_drive.oe[p])
    );
  end

  // ------------------------------------------------------------
  // status, interrupt and registered pin drive
  // ------------------------------------------------------------
  // set wins over a same-cycle clear so no level is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_sts       <= RESET_BYTE;
      drive         <= '0;
      irq_o         <= 1'b0;
      timer_clear_o <= RESET_BYTE;
    end else if (ce_i) begin
      int_sts       <= (int_sts & ~clr_mask) | active;
      drive         <= next_drive;
      irq_o         <= |(((int_sts & ~clr_mask) | active) & int_en);
      timer_clear_o <= active;
    end
  end

  assign pin_o    = drive.out;
  assign pin_oe_o = drive.oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_write_dd;
    ce_i && wr && hit_dd && sel_i[0];
  endsequence

  a_route_chan_b: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cfg.ch_sel[0] && cfg.evt_oe[0] && cfg.buf_pp[0] && cfg.polarity[0]
    |=> !ce_i || (pin_o[0] == $past(evt_b_i)))
    else $error("pin 0 does not follow channel b");
  a_sts_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && active[0] |=> int_sts[0])
    else $error("status not set at active level");
  a_evt_low: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cfg.evt_oe[1] && cfg.buf_pp[1] && !cfg.polarity[1] && !cfg.ch_sel[1] && evt_a_i
    |=> !ce_i || !pin_o[1])
    else $error("active-low event not driven low");
  a_evt_forces: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cfg.evt_oe[2] && cfg.buf_pp[2] |=> !ce_i || pin_oe_o[2])
    else $error("event enable did not force output");
  a_od_event: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cfg.evt_oe[3] && !cfg.buf_pp[3] && cfg.polarity[3] && !cfg.ch_sel[3] && evt_a_i
    |=> !ce_i || !pin_oe_o[3])
    else $error("open drain event with polarity one driven");
  a_od_data: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !cfg.buf_pp[4] && dir[4] && !cfg.evt_oe[4] && !data[4]
    |=> !ce_i || (pin_oe_o[4] && !pin_o[4]))
    else $error("open drain zero not pulled low");
  a_input_float: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !dir[5] && !cfg.evt_oe[5] |=> !ce_i || !pin_oe_o[5])
    else $error("input pin driven");
  a_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !we_i && hit_dd && dir[6] |=> dat_o[6] == $past(data[6]))
    else $error("output pin read wrong value");
  a_write_data: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_dd |=> data == $past(dat_i[7:0]))
    else $error("data write lost");
  a_clear_sts: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && clr_mask[7] && !active[7] |=> !int_sts[7])
    else $error("write one did not clear status");
endmodule : gpio_pin_config_data

// >>> hw/gpio_pkg.sv
// package: register map, field layout and timing constants of the pin block
package gpio_pkg;
  localparam int          NUM_PINS       = 8;
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] CFG_OFFSET     = 12'h1e0;
  localparam logic [11:0] DATA_DIR_OFFSET = 12'h1e4;
  localparam logic [11:0] INT_STS_OFFSET = 12'h1e8;
  localparam logic [11:0] INT_CLR_OFFSET = 12'h1ec;
  localparam logic [11:0] INT_EN_OFFSET  = 12'h1f0;
  localparam int          CH_SEL_LSB     = 24;
  localparam int          POL_LSB        = 16;
  localparam int          EVT_OE_LSB     = 8;
  localparam int          BUF_LSB        = 0;
  localparam int          DIR_LSB        = 16;
  localparam int          DATA_LSB       = 0;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          MIN_PULSE_NS   = 40;
  // a level must persist longer than the minimum pulse to be recognised
  localparam int          MIN_PULSE_CYC  = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] ch_sel;
    logic [7:0] polarity;
    logic [7:0] evt_oe;
    logic [7:0] buf_pp;
  } pin_cfg_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_s;
endpackage : gpio_pkg

// >>> hw/pin_driver.sv
// one pin: output value and enable from direction, buffer type and event routing
`timescale 1ns/1ps
module pin_driver (
  input  wire logic data_i,
  input  wire logic dir_i,
  input  wire logic evt_oe_i,
  input  wire logic buf_pp_i,
  input  wire logic polarity_i,
  input  wire logic evt_a_i,
  input  wire logic evt_b_i,
  input  wire logic ch_sel_i,
  output logic      out_o,
  output logic      oe_o
);
  wire event_now = ch_sel_i ? evt_b_i : evt_a_i;
  wire evt_level = polarity_i ? event_now : !event_now;
  wire drv_val   = evt_oe_i ? evt_level : data_i;
  wire is_out    = evt_oe_i | dir_i;
  // open drain: only low is ever driven; buffer type never overridden
  assign out_o = buf_pp_i ? drv_val : 1'b0;
  assign oe_o  = is_out && (buf_pp_i || !drv_val);
endmodule : pin_driver

// >>> hw/pin_level_filter.sv
// one pin: synchroniser and active-level persistence detector
`timescale 1ns/1ps
module pin_level_filter #(
  parameter int MIN_CYC = 4
) (
  // clock and control
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // pin side
  input  wire logic pin_i,
  input  wire logic polarity_i,
  // results
  output logic      level_o,
  output logic      active_o
);
  logic       meta;
  logic       sync;
  logic [3:0] run;
  wire        at_level = (sync == polarity_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      run  <= 4'h0;
    end else if (ce_i) begin
      meta <= pin_i;
      sync <= meta;
      run  <= !at_level ? 4'h0 : (run == 4'(MIN_CYC)) ? run : run + 4'h1;
    end
  end

  assign level_o  = sync;
  assign active_o = at_level && (run == 4'(MIN_CYC));
endmodule : pin_level_filter

// >>> tb/gpio_pin_config_data_test.sv
// self-checking bench of the pin block: registers, pin drive, interrupts
`timescale 1ns/1ps
module gpio_pin_config_data_test;
  import gpio_pkg::*;
  typedef struct packed {
    logic        we;
    logic [11:0] adr;
    logic [31:0] d;
    logic [31:0] e;
  } row_s;
  logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, evt_a_i, evt_b_i, irq_o;
  logic [11:0] adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd, c;
  logic [7:0]  timer_clear_o, pin_i, pin_o, pin_oe_o, ext;
  int          err_count, checks_done;
  row_s        rows [10];

  gpio_pin_config_data DUT (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .evt_a_i, .evt_b_i, .timer_clear_o, .pin_i, .pin_o,
    .pin_oe_o, .irq_o);
  gpio_pins_model PINS (.out_i(pin_o), .oe_i(pin_oe_o), .ext_i(ext), .pin_o(pin_i));

  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // classic cycle: hold until ack, take data at that edge, then release
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) err_count++;
  endtask : wb

  // expected {out & oe, oe} worked out per pin
  function automatic logic [15:0] drive(input logic [31:0] cf, input logic [7:0] dir, dat,
                                        input logic a, b);
    logic [7:0] o, e;
    logic       src;
    for (int i = 0; i < 8; i++) begin
      src  = cf[EVT_OE_LSB+i] ? ~(cf[CH_SEL_LSB+i] ? b : a) ^ cf[POL_LSB+i] : dat[i];
      o[i] = cf[BUF_LSB+i] & src;
      e[i] = (cf[EVT_OE_LSB+i] | dir[i]) & (cf[BUF_LSB+i] | ~src);
    end
    return {o & e, e};
  endfunction : drive

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  initial begin
    #100000;
    err_count++;
    close_out;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    err_count = 0;
    checks_done = 0;
    {rst_i, cyc_i, stb_i, we_i, evt_a_i, evt_b_i} = 6'h20;
    ce_i = 1'b1;
    adr_i = 12'h000;
    sel_i = 4'hf;
    dat_i = 32'h0;
    ext = 8'ha5;
    rows = '{'{0, CFG_OFFSET, 0, 0}, '{0, DATA_DIR_OFFSET, 0, 32'h000000a5},
             '{1, DATA_DIR_OFFSET, 32'h000f0033, 0}, '{0, DATA_DIR_OFFSET, 0, 32'h000f00a3},
             '{1, CFG_OFFSET, 32'h0000f0ff, 0}, '{0, DATA_DIR_OFFSET, 0, 32'h000f0033},
             '{1, 12'h1f4, 32'hffffffff, 0}, '{0, 12'h1f4, 0, 0},
             '{0, INT_CLR_OFFSET, 0, 0}, '{0, CFG_OFFSET, 0, 32'h0000f0ff}};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].d);
      if (rows[i].we === 1'b0) check(rd, rows[i].e);
    end
    // event routing, both buffer types and polarities, every event pair
    for (int k = 0; k < 8; k++) begin
      c = (k < 4) ? 32'h00a0f7ff : 32'h533df907;
      if (k % 4 == 0) wb(1'b1, CFG_OFFSET, c);
      evt_a_i <= k[0];
      evt_b_i <= k[1];
      repeat (2) @(posedge clk_i);
      check({16'h0, pin_o & pin_oe_o, pin_oe_o}, {16'h0, drive(c, 8'h0f, 8'h33, k[0], k[1])});
    end
    // interrupts: level trigger, sticky status, enable, clear
    wb(1'b1, CFG_OFFSET, 32'h0);
    wb(1'b1, DATA_DIR_OFFSET, 32'h0);
    ext <= 8'hff;
    repeat (4) @(posedge clk_i);
    wb(1'b1, INT_CLR_OFFSET, 32'hff);
    wb(1'b0, INT_STS_OFFSET, 32'h0);
    check(rd, 32'h0);
    ext <= 8'hfe;
    repeat (MIN_PULSE_CYC + 6) @(posedge clk_i);
    check({24'h0, timer_clear_o}, 32'h1);
    ext <= 8'hff;
    wb(1'b1, CFG_OFFSET, 32'h00020000);
    repeat (10) @(posedge clk_i);
    wb(1'b0, INT_STS_OFFSET, 32'h0);
    check(rd, 32'h3);
    check({31'h0, irq_o}, 32'h0);
    wb(1'b1, INT_EN_OFFSET, 32'h1);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h1);
    wb(1'b1, INT_CLR_OFFSET, 32'hff);
    wb(1'b0, INT_STS_OFFSET, 32'h0);
    check(rd, 32'h2);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    wb(1'b0, INT_EN_OFFSET, 32'h0);
    check(rd, 32'h1);
    // clock enable low: pin 1 drops to inactive, registered results must stay frozen
    ce_i <= 1'b0;
    ext <= 8'hfd;
    repeat (6) @(posedge clk_i);
    check({24'h0, timer_clear_o}, 32'h2);
    check({31'h0, irq_o}, 32'h0);
    ce_i <= 1'b1;
    ext <= 8'hff;
    @(posedge clk_i);
    // second reset in mid-run
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CFG_OFFSET, 32'h0);
    check(rd, 32'h0);
    check({24'h0, pin_oe_o}, 32'h0);
    check({24'h0, timer_clear_o}, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    close_out;
  end
endmodule : gpio_pin_config_data_test

// >>> tb/gpio_pins_model.sv
// external circuits on the eight pins: outside drivers, pull-ups, wire level
`timescale 1ns/1ps
module gpio_pins_model (
  // from the port
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  // outside level, pull-up where nothing drives
  input  wire logic [7:0] ext_i,
  // resolved wire level
  output logic      [7:0] pin_o
);
  // port drive wins; a floated open-drain pin shows the outside level
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : gpio_pins_model
